/* design/dsa_pkg.sv */
// Constants, types and helpers shared by the DMA slave port arbiter.
// Assumes a single core clock; all addresses are AXI byte addresses.
package dsa_pkg;

  // Decode windows of the two core-local memories
  localparam logic [31:0] IMEM_BASE = 32'h0004_0000;
  localparam logic [31:0] IMEM_LAST = 32'h0005_FFFF;
  localparam logic [31:0] DMEM_BASE = 32'h0008_0000;
  localparam logic [31:0] DMEM_LAST = 32'h0009_FFFF;

  // Wait-count default and worst-case drain after a bubble request
  localparam logic [2:0] WAIT_CNT_RST = 3'h7;
  localparam logic [2:0] IMEM_DRAIN = 3'h3;
  localparam logic [2:0] DMEM_DRAIN = 3'h4;

  // Legal write strobes and sizes
  localparam logic [7:0] STRB_LO = 8'h0F;
  localparam logic [7:0] STRB_HI = 8'hF0;
  localparam logic [7:0] STRB_ALL = 8'hFF;
  localparam logic [2:0] SIZE_WORD = 3'h2;
  localparam logic [2:0] SIZE_DWORD = 3'h3;

  // AXI response codes
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  localparam logic [1:0] RESP_DECERR = 2'h3;

  localparam int FIFO_DEPTH_DEF = 4;

  typedef struct packed {
    logic we;
    logic imem;
    logic [1:0] resp;
    logic [31:0] addr;
    logic [7:0] strb;
    logic [63:0] wdata;
  } dsa_entry_t;

  typedef enum {DSA_IDLE, DSA_RDATA, DSA_WRITE} dsa_state_t;

  // Hamming check bits plus overall parity for one 32-bit half
  function automatic logic [6:0] ecc7(input logic [31:0] d);
    logic [6:0] c;
    c = 7'h00;
    for (int i = 0; i < 32; i++) begin
      for (int k = 0; k < 6; k++) begin
        if ((((i + 1) >> k) & 1) == 1) begin
          c[k] = c[k] ^ d[i];
        end
      end
    end
    c[6] = ^{d, c[5:0]};
    return c;
  endfunction

  function automatic logic in_range(input logic [31:0] a, input logic [31:0] lo, input logic [31:0] hi);
    return (a >= lo) && (a <= hi);
  endfunction

endpackage

/* design/dsa_fifo.sv */
// Request FIFO of the DMA slave port, first word fall-through.
// Assumes synchronous reset copy and a common clock enable.
`timescale 1ns/1ps
module dsa_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // Fill side
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  // Drain side
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o,
  output logic full_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem_q [DEPTH];
  logic [AW-1:0] rd_q, rd_d, wr_q, wr_d;
  logic [AW:0] cnt_q, cnt_d;
  logic push, pop;

  function automatic logic [AW-1:0] inc(input logic [AW-1:0] p);
    return (p == AW'(DEPTH - 1)) ? '0 : p + AW'(1);
  endfunction

  assign full_o = (cnt_q == (AW+1)'(DEPTH));
  assign in_ready_o = !full_o;
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem_q[rd_q];

  always_comb begin
    push = in_valid_i && !full_o;
    pop = out_ready_i && out_valid_o;
    wr_d = push ? inc(wr_q) : wr_q;
    rd_d = pop ? inc(rd_q) : rd_q;
    cnt_d = cnt_q + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_q <= '0;
      wr_q <= '0;
      cnt_q <= '0;
    end else if (ce_i) begin
      rd_q <= rd_d;
      wr_q <= wr_d;
      cnt_q <= cnt_d;
    end
  end

  // Storage needs no reset; occupancy guards every read
  always_ff @(posedge clk_i) begin
    if (ce_i && push) begin
      mem_q[wr_q] <= in_data_i;
    end
  end
endmodule

/* design/dsa_arbiter.sv */
// DMA slave port arbiter: AXI4 single-beat slave in front of the two
// core-local memories, sharing their ports with the core pipeline.
// Assumes memories answer reads one cycle after a granted request.
`timescale 1ns/1ps
// How it works
// - Reads and writes to either local memory are served from the request FIFO.
// - Interrupt controller registers are not decoded; such requests get an error.
// - Core accesses win while the request FIFO is not full and the bubble has not drained.
// - Head request asks a bubble after the programmed wait count; zero means at once.
// - Instruction memory grant follows the bubble within 3 cycles.
// - Data memory grant follows the bubble within 4 cycles.
// - Pending core-fetch ECC correction completes before an instruction memory grant.
// - No ordering between core and DMA accesses is kept or relied upon.
// - Partial writes read, merge and rewrite the word with fresh check bits.
// - 0x0004_0000 to 0x0005_FFFF decodes to instruction memory.
// - 0x0008_0000 to 0x0009_FFFF decodes to data memory.
module dsa_arbiter import dsa_pkg::*; #(
  parameter int FIFO_DEPTH = FIFO_DEPTH_DEF
) (
  // Clock, reset, enable
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic ce_i,
  // Wait count before a bubble request
  input wire logic [2:0] wait_count_i,
  // AXI write address and data
  input wire logic awvalid_i,
  output logic awready_o,
  input wire logic [31:0] awaddr_i,
  input wire logic [2:0] awsize_i,
  input wire logic wvalid_i,
  output logic wready_o,
  input wire logic [63:0] wdata_i,
  input wire logic [7:0] wstrb_i,
  // AXI write response
  output logic bvalid_o,
  input wire logic bready_i,
  output logic [1:0] bresp_o,
  // AXI read address and data
  input wire logic arvalid_i,
  output logic arready_o,
  input wire logic [31:0] araddr_i,
  output logic rvalid_o,
  input wire logic rready_i,
  output logic [63:0] rdata_o,
  output logic [1:0] rresp_o,
  // Core pipeline side
  input wire logic core_imem_req_i,
  input wire logic core_dmem_req_i,
  input wire logic core_ecc_busy_i,
  output logic core_imem_gnt_o,
  output logic core_dmem_gnt_o,
  output logic bubble_req_o,
  // Shared memory port
  output logic mem_req_o,
  output logic mem_imem_o,
  output logic mem_we_o,
  output logic [31:0] mem_addr_o,
  output logic [63:0] mem_wdata_o,
  output logic [13:0] mem_ecc_o,
  input wire logic [63:0] mem_rdata_i
);

  ////////////////////////////////////////////////////////////////////////////
  // Reset release

  logic [1:0] rst_sync_q;
  logic rst_n;

  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      rst_sync_q <= 2'b00;
    end else begin
      rst_sync_q <= {rst_sync_q[0], 1'b1};
    end
  end
  assign rst_n = rst_sync_q[1];

  ////////////////////////////////////////////////////////////////////////////
  // Intake and decode

  dsa_entry_t in_ent, head;
  logic in_valid, in_ready, head_valid, head_pop, fifo_full;
  logic take_wr, take_rd, wr_legal;
  logic [31:0] in_addr;

  // Writes are taken ahead of reads; both need a free slot
  assign take_wr = awvalid_i && wvalid_i && in_ready;
  assign take_rd = arvalid_i && !(awvalid_i && wvalid_i) && in_ready;
  assign awready_o = take_wr;
  assign wready_o = take_wr;
  assign arready_o = take_rd;
  assign in_valid = take_wr || take_rd;
  assign in_addr = take_wr ? awaddr_i : araddr_i;

  always_comb begin
    wr_legal = ((awsize_i == SIZE_WORD) && (awaddr_i[1:0] == 2'b00) &&
                (wstrb_i == (awaddr_i[2] ? STRB_HI : STRB_LO))) ||
               ((awsize_i == SIZE_DWORD) && (awaddr_i[2:0] == 3'b000) &&
                (wstrb_i == STRB_ALL));
    in_ent.we = take_wr;
    in_ent.imem = in_range(in_addr, IMEM_BASE, IMEM_LAST);
    in_ent.addr = in_addr;
    in_ent.strb = take_wr ? wstrb_i : STRB_ALL;
    in_ent.wdata = wdata_i;
    // Anything outside both windows, interrupt registers included, is refused
    if (!in_ent.imem && !in_range(in_addr, DMEM_BASE, DMEM_LAST)) begin
      in_ent.resp = RESP_DECERR;
    end else if (take_wr && !wr_legal) begin
      in_ent.resp = RESP_SLVERR;
    end else begin
      in_ent.resp = RESP_OKAY;
    end
  end

  dsa_fifo #(
    .WIDTH($bits(dsa_entry_t)),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .clk_i(clk_i),
    .rst_n_i(rst_n),
    .ce_i(ce_i),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .in_data_i(in_ent),
    .out_valid_o(head_valid),
    .out_ready_i(head_pop),
    .out_data_o(head),
    .full_o(fifo_full)
  );

  ////////////////////////////////////////////////////////////////////////////
  // Arbitration and access sequence

  dsa_state_t state_q, state_d;
  logic [2:0] wait_q, wait_d, drain_q, drain_d;
  logic bubble_q, bubble_d;
  logic [63:0] merge_q, merge_d;
  logic resp_busy, core_tgt, dma_win, need_access, drained;
  logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
  logic [63:0] rdata_q, rdata_d;

  assign resp_busy = bvalid_q || rvalid_q;
  assign core_tgt = head.imem ? core_imem_req_i : core_dmem_req_i;
  assign need_access = head_valid && !resp_busy && (head.resp == RESP_OKAY) &&
                       (state_q != DSA_RDATA);
  // Bubble drain reaches its worst case; an ECC fix in flight holds imem off
  assign drained = bubble_q && (drain_q >= (head.imem ? IMEM_DRAIN : DMEM_DRAIN)) &&
                   !(head.imem && core_ecc_busy_i);
  // Core wins unless the FIFO is full or the bubble has drained
  // A fetch correction in flight keeps DMA off instruction memory entirely
  assign dma_win = need_access && !(head.imem && core_ecc_busy_i) &&
                   (!core_tgt || fifo_full || drained);

  assign core_imem_gnt_o = core_imem_req_i && !(dma_win && head.imem);
  assign core_dmem_gnt_o = core_dmem_req_i && !(dma_win && !head.imem);
  assign bubble_req_o = bubble_q || (need_access && !dma_win && (wait_q >= wait_count_i));

  always_comb begin
    mem_req_o = dma_win;
    mem_imem_o = head.imem;
    mem_addr_o = {head.addr[31:3], 3'b000};
    mem_we_o = head.we && (state_q == DSA_WRITE || head.strb == STRB_ALL);
    mem_wdata_o = (state_q == DSA_WRITE) ? merge_q : head.wdata;
    mem_ecc_o = {ecc7(mem_wdata_o[63:32]), ecc7(mem_wdata_o[31:0])};
  end

  always_comb begin
    state_d = state_q;
    wait_d = wait_q;
    drain_d = drain_q;
    bubble_d = bubble_q;
    merge_d = merge_q;
    head_pop = 1'b0;
    bvalid_d = bvalid_q && !bready_i;
    rvalid_d = rvalid_q && !rready_i;
    bresp_d = bresp_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    if (need_access && !dma_win) begin
      wait_d = (wait_q == 3'h7) ? wait_q : wait_q + 3'h1;
      if (wait_q >= wait_count_i) begin
        bubble_d = 1'b1;
      end
      // Count from the cycle the bubble is first asked for, so the grant meets the drain bound
      if ((bubble_q || wait_q >= wait_count_i) && drain_q != 3'h7) begin
        drain_d = drain_q + 3'h1;
      end
    end
    if (head_valid && !resp_busy && head.resp != RESP_OKAY) begin
      // Refused entries retire without touching memory
      head_pop = 1'b1;
      bvalid_d = head.we;
      rvalid_d = !head.we;
      bresp_d = head.resp;
      rresp_d = head.resp;
      rdata_d = 64'h0000_0000_0000_0000;
    end
    unique case (state_q)
      DSA_IDLE, DSA_WRITE: begin
        if (dma_win) begin
          wait_d = 3'h0;
          drain_d = 3'h0;
          bubble_d = 1'b0;
          if (head.we && state_q == DSA_IDLE && head.strb != STRB_ALL) begin
            state_d = DSA_RDATA;
          end else if (head.we) begin
            state_d = DSA_IDLE;
            head_pop = 1'b1;
            bvalid_d = 1'b1;
            bresp_d = RESP_OKAY;
          end else begin
            state_d = DSA_RDATA;
          end
        end
      end
      DSA_RDATA: begin
        if (head.we) begin
          // Merge the old word with the new half before rewriting
          for (int b = 0; b < 8; b++) begin
            merge_d[8*b +: 8] = head.strb[b] ? head.wdata[8*b +: 8] : mem_rdata_i[8*b +: 8];
          end
          state_d = DSA_WRITE;
        end else begin
          head_pop = 1'b1;
          rvalid_d = 1'b1;
          rresp_d = RESP_OKAY;
          rdata_d = mem_rdata_i;
          state_d = DSA_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= DSA_IDLE;
      wait_q <= 3'h0;
      drain_q <= 3'h0;
      bubble_q <= 1'b0;
      merge_q <= 64'h0000_0000_0000_0000;
      bvalid_q <= 1'b0;
      rvalid_q <= 1'b0;
      bresp_q <= RESP_OKAY;
      rresp_q <= RESP_OKAY;
      rdata_q <= 64'h0000_0000_0000_0000;
    end else if (ce_i) begin
      state_q <= state_d;
      wait_q <= wait_d;
      drain_q <= drain_d;
      bubble_q <= bubble_d;
      merge_q <= merge_d;
      bvalid_q <= bvalid_d;
      rvalid_q <= rvalid_d;
      bresp_q <= bresp_d;
      rresp_q <= rresp_d;
      rdata_q <= rdata_d;
    end
  end

  assign bvalid_o = bvalid_q;
  assign bresp_o = bresp_q;
  assign rvalid_o = rvalid_q;
  assign rresp_o = rresp_q;
  assign rdata_o = rdata_q;
endmodule

/* verification/dsa_arbiter_assertions.sv */
// Concurrent checks on the DMA slave port arbiter.
// Assumes a bind onto dsa_arbiter; sees its ports only.
`timescale 1ns/1ps
module dsa_arbiter_assertions import dsa_pkg::*; (
  // Clock and reset
  input wire logic clk_i,
  input wire logic reset_n_i,
  // Watched ports
  input wire logic core_imem_req_i,
  input wire logic core_ecc_busy_i,
  input wire logic core_imem_gnt_o,
  input wire logic core_dmem_gnt_o,
  input wire logic bubble_req_o,
  input wire logic mem_req_o,
  input wire logic mem_imem_o,
  input wire logic mem_we_o,
  input wire logic [31:0] mem_addr_o,
  input wire logic bvalid_o,
  input wire logic bready_i,
  input wire logic [1:0] bresp_o,
  input wire logic rvalid_o,
  input wire logic rready_i,
  input wire logic [63:0] rdata_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!reset_n_i);
  // Bubble start with no fetch correction pending, which may stretch it
  sequence bub_s;
    $rose(bubble_req_o) && !core_ecc_busy_i;
  endsequence
  sequence dma_s;
    mem_req_o;
  endsequence
  grant_excl_a: assert property (mem_req_o |-> !(mem_imem_o ? core_imem_gnt_o : core_dmem_gnt_o))
    else $error("core and dma share a memory cycle");
  imem_drain_a: assert property (bub_s ##0 mem_imem_o |-> ##[0:3] dma_s)
    else $error("instruction memory grant late");
  dmem_drain_a: assert property (bub_s ##0 !mem_imem_o |-> ##[0:4] dma_s)
    else $error("data memory grant late");
  ecc_hold_a: assert property (core_ecc_busy_i && core_imem_req_i && bubble_req_o |-> !(mem_req_o && mem_imem_o))
    else $error("grant during fetch correction");
  imem_map_a: assert property (mem_req_o && mem_imem_o |-> mem_addr_o inside {[IMEM_BASE:IMEM_LAST]} &&
    mem_addr_o[2:0] == 3'h0)
    else $error("instruction memory address outside window");
  dmem_map_a: assert property (mem_req_o && !mem_imem_o |-> mem_addr_o inside {[DMEM_BASE:DMEM_LAST]})
    else $error("data memory address outside window");
  bresp_hold_a: assert property (bvalid_o && !bready_i |=> bvalid_o && $stable(bresp_o))
    else $error("write response dropped");
  rdata_hold_a: assert property (rvalid_o && !rready_i |=> rvalid_o && $stable(rdata_o))
    else $error("read data dropped");
  wr_resp_a: assert property (mem_req_o && mem_we_o |-> ##[1:3] bvalid_o)
    else $error("no write response after memory write");
endmodule

/* verification/dsa_axi_master.sv */
// AXI master model issuing single-beat DMA transfers.
// Assumes the bench top is tb; changes signals at the falling edge.
`timescale 1ns/1ps
module dsa_axi_master (
  // Clock
  input wire logic clk_i,
  // Write channels
  output logic awvalid_o,
  output logic [31:0] awaddr_o,
  output logic [2:0] awsize_o,
  output logic wvalid_o,
  output logic [63:0] wdata_o,
  output logic [7:0] wstrb_o,
  input wire logic awready_i,
  input wire logic wready_i,
  input wire logic bvalid_i,
  input wire logic [1:0] bresp_i,
  output logic bready_o,
  // Read channels
  output logic arvalid_o,
  output logic [31:0] araddr_o,
  input wire logic arready_i,
  input wire logic rvalid_i,
  input wire logic [63:0] rdata_i,
  input wire logic [1:0] rresp_i,
  output logic rready_o
);
  initial begin
    {awvalid_o, wvalid_o, bready_o, arvalid_o, rready_o} = 5'h00;
    {awaddr_o, awsize_o, wdata_o, wstrb_o, araddr_o} = '0;
  end
  // Bounded wait on one handshake; a hang ends the run
  task automatic wt(input int k);
    int n;
    n = 0;
    // Look once inputs have settled; an address take happens at the next rising edge
    #10;
    while (!(k == 0 ? awready_i && wready_i : k == 1 ? bvalid_i : k == 2 ? arready_i : rvalid_i)) begin
      @(negedge clk_i);
      #10;
      n++;
      if (n > 300) begin
        tb.error_cnt++;
        tb.report_and_stop();
      end
    end
    @(posedge clk_i);
  endtask
  // Response accepted a cycle late so the slave must hold it
  task automatic wr(input logic [31:0] a, input logic [2:0] s, input logic [7:0] b, output logic [1:0] r);
    @(negedge clk_i);
    awaddr_o = a;
    awsize_o = s;
    wstrb_o = b;
    wdata_o = {~a, a};
    awvalid_o = 1'b1;
    wvalid_o = 1'b1;
    wt(0);
    @(negedge clk_i);
    {awvalid_o, wvalid_o} = 2'h0;
    awaddr_o = ~awaddr_o;
    wdata_o = ~wdata_o;
    wt(1);
    @(negedge clk_i);
    bready_o = 1'b1;
    r = bresp_i;
    @(negedge clk_i);
    bready_o = 1'b0;
  endtask
  task automatic rd(input logic [31:0] a, output logic [63:0] d, output logic [1:0] r);
    @(negedge clk_i);
    araddr_o = a;
    arvalid_o = 1'b1;
    wt(2);
    @(negedge clk_i);
    arvalid_o = 1'b0;
    araddr_o = ~araddr_o;
    wt(3);
    @(negedge clk_i);
    rready_o = 1'b1;
    d = rdata_i;
    r = rresp_i;
    @(negedge clk_i);
    rready_o = 1'b0;
  endtask
endmodule

/* verification/tb.sv */
// Self-checking bench of the DMA slave port arbiter.
// Assumes the checker and the master model are compiled first.
`timescale 1ns/1ps
module tb;
  import dsa_pkg::*;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic [2:0] wait_count_i = 3'h0;
  logic core_imem_req_i = 1'b0;
  logic core_dmem_req_i = 1'b0;
  logic core_ecc_busy_i = 1'b0;
  logic [63:0] mem_rdata_i = 64'h0;
  logic awvalid_i, awready_o, wvalid_i, wready_o, bvalid_o, bready_i, arvalid_i, arready_o, rvalid_o, rready_i;
  logic [31:0] awaddr_i, araddr_i, mem_addr_o;
  logic [2:0] awsize_i;
  logic [63:0] wdata_i, rdata_o, d;
  logic [7:0] wstrb_i;
  logic [63:0] mem_wdata_o, wr_data_q;
  logic [13:0] mem_ecc_o, wr_ecc_q;
  logic [1:0] bresp_o, rresp_o, r;
  logic core_imem_gnt_o, core_dmem_gnt_o, bubble_req_o, mem_req_o, mem_imem_o, mem_we_o, done;
  int error_cnt = 0;
  int total_checks = 0;
  always #50 clk_i = ~clk_i;
  // Memory returns its own dword address pattern; no ordering assumed
  always @(posedge clk_i) mem_rdata_i <= mem_req_o ? {~mem_addr_o, mem_addr_o} : ~mem_rdata_i;
  // Last word written to memory, for the merge check
  always @(posedge clk_i) if (mem_req_o && mem_we_o) {wr_data_q, wr_ecc_q} <= {mem_wdata_o, mem_ecc_o};
  dsa_arbiter dsa_arbiter_i (.clk_i, .reset_n_i, .ce_i(1'b1), .wait_count_i, .awvalid_i, .awready_o, .awaddr_i,
    .awsize_i, .wvalid_i, .wready_o, .wdata_i, .wstrb_i, .bvalid_o, .bready_i, .bresp_o, .arvalid_i, .arready_o,
    .araddr_i, .rvalid_o, .rready_i, .rdata_o, .rresp_o, .core_imem_req_i, .core_dmem_req_i, .core_ecc_busy_i,
    .core_imem_gnt_o, .core_dmem_gnt_o, .bubble_req_o, .mem_req_o, .mem_imem_o, .mem_we_o, .mem_addr_o,
    .mem_wdata_o, .mem_ecc_o, .mem_rdata_i);
  dsa_axi_master dsa_axi_master_i (.clk_i, .awvalid_o(awvalid_i), .awaddr_o(awaddr_i), .awsize_o(awsize_i),
    .wvalid_o(wvalid_i), .wdata_o(wdata_i), .wstrb_o(wstrb_i), .awready_i(awready_o), .wready_i(wready_o),
    .bvalid_i(bvalid_o), .bresp_i(bresp_o), .bready_o(bready_i), .arvalid_o(arvalid_i), .araddr_o(araddr_i),
    .arready_i(arready_o), .rvalid_i(rvalid_o), .rdata_i(rdata_o), .rresp_i(rresp_o), .rready_o(rready_i));
  task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////
  task automatic t_map();
    logic [31:0] a [8];
    a = '{IMEM_BASE, IMEM_LAST - 32'h7, DMEM_BASE, DMEM_LAST - 32'h7, 32'h0003_FFF8, 32'h0006_0000,
      32'h000A_0000, 32'h1000_0000};
    for (int i = 0; i < 8; i++) begin
      dsa_axi_master_i.rd(a[i], d, r);
      chk("rresp", {62'h0, (i < 4) ? RESP_OKAY : RESP_DECERR}, {62'h0, r});
      if (i < 4) begin
        chk("rdata", {~(a[i] & ~32'h7), a[i] & ~32'h7}, d);
      end
    end
    $display("t_map done");
  endtask
  task automatic t_wr();
    logic [44:0] v [7];
    v = '{{IMEM_BASE, SIZE_DWORD, STRB_ALL, RESP_OKAY}, {DMEM_BASE + 32'h8, SIZE_WORD, STRB_LO, RESP_OKAY},
      {DMEM_BASE + 32'hC, SIZE_WORD, STRB_HI, RESP_OKAY}, {DMEM_BASE, 3'h1, 8'h03, RESP_SLVERR},
      {IMEM_BASE + 32'h4, SIZE_DWORD, STRB_ALL, RESP_SLVERR}, {DMEM_BASE, SIZE_DWORD, 8'h3C, RESP_SLVERR},
      {32'h0006_0000, SIZE_DWORD, STRB_ALL, RESP_DECERR}};
    for (int i = 0; i < 7; i++) begin
      dsa_axi_master_i.wr(v[i][44:13], v[i][12:10], v[i][9:2], r);
      chk("bresp", {62'h0, v[i][1:0]}, {62'h0, r});
      if (i == 2) begin
        chk("merge", {~(DMEM_BASE + 32'hC), DMEM_BASE + 32'h8}, wr_data_q);
        chk("ecc", 64'h0, {62'h0, ^{wr_data_q[63:32], wr_ecc_q[13:7]}, ^{wr_data_q[31:0], wr_ecc_q[6:0]}});
      end
    end
    $display("t_wr done");
  endtask
  // Core holds both memories, so only the bubble lets DMA in
  task automatic t_qos();
    time t0;
    int n;
    for (int i = 0; i < 4; i++) begin
      wait_count_i = i[0] ? 3'h7 : 3'h0;
      {core_imem_req_i, core_dmem_req_i} = 2'h3;
      t0 = $time;
      dsa_axi_master_i.rd(i[1] ? IMEM_BASE : DMEM_BASE, d, r);
      n = int'(($time - t0) / 100);
      chk("late", 64'h1, {63'h0, n >= wait_count_i + 3});
      chk("wait", 64'h1, {63'h0, n <= wait_count_i + 12});
    end
    {core_imem_req_i, core_dmem_req_i} = 2'h0;
    $display("t_qos done");
  endtask
  task automatic t_ecc();
    wait_count_i = 3'h0;
    core_imem_req_i = 1'b1;
    core_ecc_busy_i = 1'b1;
    done = 1'b0;
    fork
      begin
        dsa_axi_master_i.rd(IMEM_BASE, d, r);
        done = 1'b1;
      end
    join_none
    repeat (15) @(negedge clk_i);
    chk("held", 64'h0, {63'h0, done});
    core_ecc_busy_i = 1'b0;
    for (int k = 0; k < 10 && !done; k++) @(negedge clk_i);
    chk("done", 64'h1, {63'h0, done});
    chk("rresp", {62'h0, RESP_OKAY}, {62'h0, r});
    core_imem_req_i = 1'b0;
    $display("t_ecc done");
  endtask
  initial begin
    repeat (4) @(negedge clk_i);
    reset_n_i = 1'b1;
    repeat (3) @(negedge clk_i);
    t_map();
    t_wr();
    t_qos();
    t_ecc();
    report_and_stop();
  end
endmodule
bind dsa_arbiter dsa_arbiter_assertions dsa_arbiter_assertions_i (.clk_i, .reset_n_i, .core_imem_req_i,
  .core_ecc_busy_i, .core_imem_gnt_o, .core_dmem_gnt_o, .bubble_req_o, .mem_req_o, .mem_imem_o, .mem_we_o,
  .mem_addr_o, .bvalid_o, .bready_i, .bresp_o, .rvalid_o, .rready_i, .rdata_o);
